// >>> src/lss_defs.svh
`ifndef LSS_DEFS_SVH
`define LSS_DEFS_SVH
// ==========================================================================
// Overview of operation
// R01: Idle data lanes with a live clock lane give an all-ones word.
// R02: With clock and data lanes all idle, the last good word is held.
// R03: With the clock lane idle, the recovered clock output is high.
// R04: Each lane carries seven slots per strobe period, one per link clock.
// R05: The link has five pairs: four data lanes and one forwarded clock lane.
// R06: A low sleep input keeps that end in powerdown while it stays low.
// R07: After wake-up the transmitter waits 10 ms before its lanes toggle.
// R08: The host runs the strobe clock while awake and never wakes without it.
// R09: If the strobe clock stops, the host holds sleep low until it is back.
// R10: When the far transmitter dies and its clock stops, the word is held.
// R11: While the receiver sleeps, its parallel outputs are forced low.
// R12: The transmitter takes the word on the rising edge of the strobe clock.
// R13: Word bit lane*7+slot travels on that lane in that slot, at both ends.
// ==========================================================================
`define LSS_WORD_W 28
`define LSS_LANES 4
`define LSS_SLOTS 7
`define LSS_LAST_SLOT 3'h6
`define LSS_CLK_HI_SLOTS 3'h4
`define LSS_LOST_LIMIT 4'he
`define LSS_WORD_RST 28'h0000000
`define LSS_START_DELAY_MS 10
`define LSS_CLK_SYS_KHZ 25000
`define LSS_START_CYC (`LSS_START_DELAY_MS * `LSS_CLK_SYS_KHZ)
`endif

// >>> src/lss_pkg.sv
`include "lss_defs.svh"
package lss_pkg;
  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    LSS_TX_SLEEP = 2'b00,
    LSS_TX_WAIT = 2'b01,
    LSS_TX_RUN = 2'b10
  } lss_tx_state_e;

  typedef logic [`LSS_WORD_W-1:0] lss_word_t;
  typedef logic [`LSS_LANES-1:0] lss_lanes_t;
endpackage : lss_pkg

// >>> src/lss_sync.sv
`timescale 1ns/100ps
module lss_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  // ==========================================================================
  // Two-stage synchroniser; the first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : lss_sync

// >>> src/lss_top.sv
`timescale 1ns/100ps
`include "lss_defs.svh"
module lss_top #(
  parameter int unsigned START_CYC = `LSS_START_CYC,
  parameter logic [3:0] LOST_LIMIT = `LSS_LOST_LIMIT
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic clk_link_i,
  input wire logic tx_sleep_n_i,
  input wire lss_pkg::lss_word_t tx_parallel_in_i,
  output lss_pkg::lss_lanes_t tx_serial_out_o,
  output logic tx_clock_lane_o,
  output logic tx_active_o,
  input wire logic rx_sleep_n_i,
  input wire lss_pkg::lss_lanes_t rx_serial_in_i,
  input wire logic rx_clock_lane_i,
  output lss_pkg::lss_word_t rx_parallel_out_o,
  output logic rx_recovered_clock_out_o,
  output logic rx_clock_lost_o
);
  import lss_pkg::*;

  // ==========================================================================
  // Shared bit mapping between lane/slot and word position
  function automatic logic [4:0] lss_bit_idx(input logic [1:0] lane,
                                             input logic [2:0] slot);
    return 5'(lane * `LSS_SLOTS + slot);
  endfunction : lss_bit_idx

  // ==========================================================================
  // Synchronisers
  logic tx_awake;
  logic link_rst;
  logic tx_run_l;
  logic rx_awake;
  lss_word_t tx_din;
  lss_lanes_t rx_data_s;
  logic rx_clk_s;

  lss_sync #(.W(1)) u_sys_sleep (
    .clk_i(clk_sys_i),
    .rst_i(sys_rst_i),
    .d_i(tx_sleep_n_i),
    .q_o(tx_awake)
  );

  // Link reset is released a couple of link edges after the system reset
  lss_sync #(.W(1)) u_link_rst (
    .clk_i(clk_link_i),
    .rst_i(1'b0),
    .d_i(sys_rst_i),
    .q_o(link_rst)
  );

  lss_sync #(.W(2)) u_link_ctl (
    .clk_i(clk_link_i),
    .rst_i(link_rst),
    .d_i({tx_active_o, rx_sleep_n_i}),
    .q_o({tx_run_l, rx_awake})
  );

  // No reset: a cleared stage would read as a false clock-lane rise later
  lss_sync #(.W(`LSS_WORD_W + `LSS_LANES + 1)) u_link_din (
    .clk_i(clk_link_i),
    .rst_i(1'b0),
    .d_i({tx_parallel_in_i, rx_serial_in_i, rx_clock_lane_i}),
    .q_o({tx_din, rx_data_s, rx_clk_s})
  );

  // ==========================================================================
  // Transmitter wake-up sequencing (system clock)
  lss_tx_state_e tx_state;
  lss_tx_state_e next_tx_state;
  logic [23:0] wait_cnt;
  logic [23:0] next_wait_cnt;
  wire wait_done = (wait_cnt == 24'(START_CYC - 1));

  always_comb begin
    next_tx_state = tx_state;
    unique case (tx_state)
      LSS_TX_SLEEP: begin
        if (tx_awake) begin
          next_tx_state = LSS_TX_WAIT;
        end
      end
      LSS_TX_WAIT: begin
        if (!tx_awake) begin
          next_tx_state = LSS_TX_SLEEP; // R06
        end else if (wait_done) begin
          next_tx_state = LSS_TX_RUN; // R07
        end
      end
      LSS_TX_RUN: begin
        if (!tx_awake) begin
          next_tx_state = LSS_TX_SLEEP; // R06
        end
      end
      default: begin
        next_tx_state = LSS_TX_SLEEP;
      end
    endcase
  end

  // Start-up delay counts only while waiting; any sleep restarts it
  assign next_wait_cnt = (tx_state == LSS_TX_WAIT) ? wait_cnt + 24'h000001
                                                   : 24'h000000; // R07

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tx_state <= LSS_TX_SLEEP;
      wait_cnt <= 24'h000000;
      tx_active_o <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      wait_cnt <= next_wait_cnt;
      tx_active_o <= (next_tx_state == LSS_TX_RUN);
    end
  end

  // ==========================================================================
  // Transmitter serialiser (link clock = bit clock, seven per strobe)
  logic [2:0] tx_slot;
  lss_word_t tx_cap;
  lss_lanes_t next_tx_lanes;
  wire tx_strobe_edge = tx_run_l && (tx_slot == `LSS_LAST_SLOT);
  wire [2:0] next_tx_slot = tx_strobe_edge ? 3'h0
                                           : tx_slot + 3'h1; // R04

  genvar gl;
  generate
    for (gl = 0; gl < `LSS_LANES; gl++) begin : g_tx_lane
      assign next_tx_lanes[gl] =
        tx_cap[lss_bit_idx(2'(gl), tx_slot)]; // R13
    end
  endgenerate

  // Outputs lag the slot counter by one edge, clock lane included, so
  // data and forwarded clock stay aligned at the pins
  always_ff @(posedge clk_link_i) begin
    if (link_rst || !tx_run_l) begin
      tx_slot <= 3'h0;
      tx_serial_out_o <= '0; // R06
      tx_clock_lane_o <= 1'b0;
    end else begin
      tx_slot <= next_tx_slot;
      tx_serial_out_o <= next_tx_lanes; // R05
      tx_clock_lane_o <= (tx_slot < `LSS_CLK_HI_SLOTS); // R05
    end
  end

  // Word is taken at the end of slot 6, one link edge before the forwarded clock rises
  always_ff @(posedge clk_link_i) begin
    if (link_rst) begin
      tx_cap <= `LSS_WORD_RST;
    end else if (tx_strobe_edge) begin
      tx_cap <= tx_din; // R12
    end
  end

  // ==========================================================================
  // Receiver deserialiser and failsafe
  logic rx_clk_prev;
  logic [2:0] rx_slot;
  logic [3:0] lost_cnt;
  lss_word_t rx_acc;
  wire rx_clk_rise = rx_clk_s && !rx_clk_prev;
  wire rx_lost = (lost_cnt == LOST_LIMIT);
  wire [2:0] rx_cur_slot =
    rx_clk_rise ? 3'h0 :
    (rx_slot == `LSS_LAST_SLOT) ? `LSS_LAST_SLOT : rx_slot + 3'h1;
  wire rx_frame_ok = rx_clk_rise && !rx_lost &&
                     (rx_slot == `LSS_LAST_SLOT);
  wire [3:0] next_lost_cnt =
    rx_clk_rise ? 4'h0 : rx_lost ? lost_cnt : lost_cnt + 4'h1;

  // Idle lanes read high, so a missing clock never rises; the counter
  // turns that silence into the lost state
  always_ff @(posedge clk_link_i) begin
    if (link_rst) begin
      rx_clk_prev <= 1'b1;
      rx_slot <= 3'h0;
      lost_cnt <= LOST_LIMIT;
    end else begin
      rx_clk_prev <= rx_clk_s;
      rx_slot <= rx_cur_slot;
      lost_cnt <= next_lost_cnt; // R03
    end
  end

  always_ff @(posedge clk_link_i) begin
    if (link_rst) begin
      rx_acc <= `LSS_WORD_RST;
    end else begin
      for (int l = 0; l < `LSS_LANES; l++) begin
        rx_acc[lss_bit_idx(2'(l), rx_cur_slot)] <= rx_data_s[l]; // R13
      end
    end
  end

  // Sleep clears the word; while awake only a complete frame replaces it, otherwise it is held
  always_ff @(posedge clk_link_i) begin
    if (link_rst || !rx_awake) begin
      rx_parallel_out_o <= `LSS_WORD_RST; // R11
    end else if (rx_frame_ok) begin // R02
      rx_parallel_out_o <= rx_acc; // R01
    end
  end

  always_ff @(posedge clk_link_i) begin
    if (link_rst || !rx_awake) begin
      rx_recovered_clock_out_o <= 1'b0; // R06
      rx_clock_lost_o <= 1'b0;
    end else begin
      rx_recovered_clock_out_o <= rx_lost || rx_clk_s; // R03
      rx_clock_lost_o <= rx_lost; // R10
    end
  end

  // ==========================================================================
  // Assertions
  a_tx_sleep_state: assert property ( // R06
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !tx_awake |=> (tx_state == LSS_TX_SLEEP) && !tx_active_o)
    else $error("transmitter not asleep after sleep input low");

  a_start_delay_len: assert property ( // R07
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(tx_active_o) |-> $past(wait_cnt) == 24'(START_CYC - 1))
    else $error("transmitter started before the start delay ended");

  a_tx_idle_low: assert property ( // R06
    @(posedge clk_link_i) disable iff (link_rst)
    !tx_run_l |=> (tx_serial_out_o == '0) && !tx_clock_lane_o)
    else $error("transmitter lanes toggle while not running");

  a_tx_slot_wrap: assert property ( // R04
    @(posedge clk_link_i) disable iff (link_rst)
    (tx_run_l && tx_slot == 3'h0) ##1 tx_run_l[*6]
    |=> tx_slot == 3'h0 && $past(tx_slot) == 3'h6)
    else $error("slot counter out of step");

  a_tx_clock_shape: assert property ( // R05
    @(posedge clk_link_i) disable iff (link_rst)
    (tx_run_l && tx_slot == 3'h6) ##1 tx_run_l[*5]
    |=> !tx_clock_lane_o && $past(tx_clock_lane_o, 4)
        && $past(tx_clock_lane_o, 3))
    else $error("forwarded clock lane pattern wrong");

  a_tx_word_take: assert property ( // R12
    @(posedge clk_link_i) disable iff (link_rst)
    tx_strobe_edge |=> tx_cap == $past(tx_din))
    else $error("word not taken on strobe edge");

  a_tx_lane_map: assert property ( // R13
    @(posedge clk_link_i) disable iff (link_rst)
    (tx_run_l && tx_slot == 3'h2) ##1 tx_run_l
    |-> tx_serial_out_o[1] == tx_cap[9])
    else $error("lane 1 slot 2 carries the wrong bit");

  a_rx_sleep_low: assert property ( // R11
    @(posedge clk_link_i) disable iff (link_rst)
    !rx_awake |=> rx_parallel_out_o == '0 && !rx_recovered_clock_out_o)
    else $error("receiver outputs not low in powerdown");

  a_rx_clock_high: assert property ( // R03
    @(posedge clk_link_i) disable iff (link_rst)
    (rx_clk_s && rx_awake)[*8] ##1 (rx_clk_s && rx_awake)[*8]
    |=> rx_recovered_clock_out_o && rx_clock_lost_o)
    else $error("recovered clock not high with idle clock lane");

  a_rx_hold_last: assert property ( // R02
    @(posedge clk_link_i) disable iff (link_rst)
    (rx_lost && rx_awake)[*2] |-> $stable(rx_parallel_out_o))
    else $error("parallel outputs changed without a clock");

  a_rx_all_ones: assert property ( // R01
    @(posedge clk_link_i) disable iff (link_rst)
    rx_frame_ok && rx_awake && rx_acc == '1 |=> rx_parallel_out_o == '1)
    else $error("idle data lanes did not give all ones");

  a_rx_frame_load: assert property ( // R13
    @(posedge clk_link_i) disable iff (link_rst)
    rx_frame_ok && rx_awake |=> rx_parallel_out_o == $past(rx_acc))
    else $error("complete frame not loaded into the word");

  a_rx_hold_idle: assert property ( // R02
    @(posedge clk_link_i) disable iff (link_rst)
    rx_awake && !rx_frame_ok |=> $stable(rx_parallel_out_o))
    else $error("word changed without a complete frame");

  a_tx_lane_slot0: assert property ( // R13
    @(posedge clk_link_i) disable iff (link_rst)
    tx_run_l && tx_slot == 3'h0 |=> tx_serial_out_o[3] == $past(tx_cap[21]))
    else $error("lane 3 slot 0 carries the wrong bit");

  c_tx_running: cover property (
    @(posedge clk_sys_i) disable iff (sys_rst_i) $rose(tx_active_o));
  c_rx_frame: cover property (
    @(posedge clk_link_i) disable iff (link_rst) rx_frame_ok && rx_awake);
  c_rx_lost: cover property (
    @(posedge clk_link_i) disable iff (link_rst) $rose(rx_clock_lost_o));
  c_rx_sleep: cover property (
    @(posedge clk_link_i) disable iff (link_rst) $fell(rx_awake));
endmodule : lss_top

// >>> verification/lss_far_end.sv
`timescale 1ns/100ps
module lss_far_end (
  input wire logic clk_link_i,
  input wire logic [1:0] mode_i,
  input wire lss_pkg::lss_word_t word_i,
  input wire lss_pkg::lss_lanes_t tx_lanes_i,
  input wire logic tx_clk_lane_i,
  output lss_pkg::lss_lanes_t rx_lanes_o,
  output logic rx_clk_lane_o,
  output lss_pkg::lss_word_t got_word_o,
  output logic got_o
);
  import lss_pkg::*;
  // ==========================================================================
  // Mode 0 sends frames, 1 leaves data lanes idle, 2 leaves all lanes idle
  logic [2:0] tslot = 3'h0;
  logic [2:0] rslot = 3'h7;
  logic prev_cl = 1'b0;
  lss_word_t cur = '0;
  lss_word_t acc = '0;
  initial begin
    rx_lanes_o = '1;
    rx_clk_lane_o = 1'b1;
    got_word_o = '0;
    got_o = 1'b0;
  end
  // ==========================================================================
  // Sender: word latched whole so a frame never mixes two words
  always @(posedge clk_link_i) begin
    tslot <= (tslot == 3'h6) ? 3'h0 : tslot + 3'h1;
    if (tslot == 3'h6) begin
      cur <= word_i;
    end
    rx_clk_lane_o <= (mode_i == 2'h2) ? 1'b1 : (tslot < 3'h4);
    for (int l = 0; l < 4; l++) begin
      rx_lanes_o[l] <= (mode_i != 2'h0) ? 1'b1 : cur[l*7+tslot];
    end
  end
  // ==========================================================================
  // Receiver: clock lane rise marks slot 0
  always @(posedge clk_link_i) begin
    prev_cl <= tx_clk_lane_i;
    got_o <= 1'b0;
    if (tx_clk_lane_i && !prev_cl) begin
      rslot = 3'h0;
    end else if (rslot != 3'h7) begin
      rslot = rslot + 3'h1;
    end
    if (rslot != 3'h7) begin
      for (int l = 0; l < 4; l++) begin
        acc[l*7+rslot] = tx_lanes_i[l];
      end
    end
    if (rslot == 3'h6) begin
      got_word_o <= acc;
      got_o <= 1'b1;
    end
  end
endmodule : lss_far_end

// >>> verification/tb.sv
`timescale 1ns/100ps
module tb;
  import lss_pkg::*;
  localparam int unsigned START_CYC = 20;
  logic clk_sys_i = 1'b0;
  logic clk_link_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic tx_sleep_n_i = 1'b0;
  logic rx_sleep_n_i = 1'b0;
  lss_word_t tx_parallel_in_i = '0;
  lss_word_t far_word = '0;
  logic [1:0] far_mode = 2'h2;
  lss_lanes_t tx_serial_out_o;
  lss_lanes_t rx_serial_in_i;
  logic tx_clock_lane_o;
  logic tx_active_o;
  logic rx_clock_lane_i;
  lss_word_t rx_parallel_out_o;
  logic rx_recovered_clock_out_o;
  logic rx_clock_lost_o;
  lss_word_t far_got_word;
  logic far_got;
  int n_fail = 0;
  int cmp_count = 0;
  int seed = 32'h14c3;
  int n;
  lss_word_t w;
  lss_word_t exp_q[$];
  // ==========================================================================
  // Clocks never stop while awake
  always #20 clk_sys_i = ~clk_sys_i;
  initial begin
    #7.3;
    forever #32 clk_link_i = ~clk_link_i;
  end
  lss_top #(.START_CYC(START_CYC)) u_dut (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .clk_link_i(clk_link_i),
    .tx_sleep_n_i(tx_sleep_n_i),
    .tx_parallel_in_i(tx_parallel_in_i),
    .tx_serial_out_o(tx_serial_out_o),
    .tx_clock_lane_o(tx_clock_lane_o),
    .tx_active_o(tx_active_o),
    .rx_sleep_n_i(rx_sleep_n_i),
    .rx_serial_in_i(rx_serial_in_i),
    .rx_clock_lane_i(rx_clock_lane_i),
    .rx_parallel_out_o(rx_parallel_out_o),
    .rx_recovered_clock_out_o(rx_recovered_clock_out_o),
    .rx_clock_lost_o(rx_clock_lost_o)
  );
  lss_far_end u_far (
    .clk_link_i(clk_link_i),
    .mode_i(far_mode),
    .word_i(far_word),
    .tx_lanes_i(tx_serial_out_o),
    .tx_clk_lane_i(tx_clock_lane_o),
    .rx_lanes_o(rx_serial_in_i),
    .rx_clk_lane_o(rx_clock_lane_i),
    .got_word_o(far_got_word),
    .got_o(far_got)
  );
  // ==========================================================================
  // Checking
  task automatic check(input lss_word_t seen, input lss_word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_link_i) begin
    if (far_got === 1'b1 && exp_q.size() > 0) begin
      check(far_got_word, exp_q.pop_front());
    end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    check({tx_active_o, tx_serial_out_o, tx_clock_lane_o}, 0);
    check($bits(tx_serial_out_o) + 1, 5);
    // Aborted wake must restart the delay from zero
    tx_sleep_n_i = 1'b1;
    repeat (10) @(negedge clk_sys_i);
    tx_sleep_n_i = 1'b0;
    repeat (START_CYC + 10) @(negedge clk_sys_i);
    check(tx_active_o, 0);
    tx_sleep_n_i = 1'b1;
    for (n = 0; n < START_CYC + 20 && tx_active_o !== 1'b1; n++) begin
      check(tx_clock_lane_o, 0);
      @(negedge clk_sys_i);
    end
    check(n >= START_CYC + 2 && n <= START_CYC + 6, 1);
    rx_sleep_n_i = 1'b1;
    far_mode = 2'h0;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_sys_i);
      w = lss_word_t'($random(seed));
      tx_parallel_in_i = w;
      far_word = ~w;
      repeat (40) @(posedge clk_link_i);
      exp_q.push_back(w);
      check(rx_parallel_out_o, ~w);
      check(rx_clock_lost_o, 0);
      for (n = 0; n < 100 && exp_q.size() > 0; n++) @(posedge clk_link_i);
      check(exp_q.size() == 0, 1);
    end
    @(negedge clk_sys_i);
    far_mode = 2'h1;
    repeat (30) @(posedge clk_link_i);
    check(rx_parallel_out_o, 28'hfffffff);
    @(negedge clk_sys_i);
    far_mode = 2'h0;
    far_word = 28'h5a5a5a5;
    repeat (30) @(posedge clk_link_i);
    @(negedge clk_sys_i);
    far_mode = 2'h2;
    repeat (30) @(posedge clk_link_i);
    check(rx_parallel_out_o, 28'h5a5a5a5);
    check(rx_recovered_clock_out_o, 1);
    check(rx_clock_lost_o, 1);
    @(negedge clk_sys_i);
    rx_sleep_n_i = 1'b0;
    tx_sleep_n_i = 1'b0;
    repeat (10) @(posedge clk_link_i);
    check(rx_parallel_out_o, 28'h0000000);
    check(rx_recovered_clock_out_o, 0);
    check({tx_active_o, tx_serial_out_o, tx_clock_lane_o}, 0);
    tally_and_finish();
  end
endmodule : tb
